/* File: dv/rucn_chan_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rucn_chan_model #(
    parameter int N = 4
) (
    // clock and burst control
    input  wire logic         core_clk,
    input  wire logic         start,
    input  wire logic [7:0]   num,
    // recovered clock to the block
    output var  logic [N-1:0] rec_clk
);
    logic [7:0] left_ff = 8'h00;
    logic [1:0] ph_ff   = 2'h0;
    initial rec_clk = '0;
    // each level stands three cycles, the clock stands still between bursts
    // burst control is sampled on the rising edge, away from the bench's falling-edge drive
    always @(posedge core_clk) begin
        if (start) begin
            left_ff <= num;
            ph_ff   <= 2'h0;
        end else if (left_ff != 8'h00) begin
            ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
            if (ph_ff == 2'h2) begin
                rec_clk <= ~rec_clk;
                left_ff <= left_ff - 8'h01;
            end
        end
    end
endmodule // rucn_chan_model
`default_nettype wire

/* File: dv/rucn_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rucn_top_sva #(
    parameter int NUM_CHANNELS = 4,
    parameter int MASTER_CHAN  = 0
) (
    input wire logic                    core_clk,
    input wire logic                    reset,
    input wire logic [NUM_CHANNELS-1:0] rx_recovered_clock_out,
    input wire logic [NUM_CHANNELS-1:0] rx_datapath_clock_in,
    input wire logic [NUM_CHANNELS-1:0] rx_interface_clock_in,
    input wire logic [NUM_CHANNELS-1:0] user_clk_reset,
    input wire logic [NUM_CHANNELS-1:0] source_clock_out,
    input wire logic [NUM_CHANNELS-1:0] datapath_clock_out,
    input wire logic [NUM_CHANNELS-1:0] interface_clock_out,
    input wire logic [NUM_CHANNELS-1:0] user_clk_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [2:0] up_ff;
    wire  logic ur = user_clk_reset[MASTER_CHAN];
    wire  logic act = user_clk_active[MASTER_CHAN];
    // cycles since core or user reset, saturating
    always_ff @(posedge core_clk) up_ff <= (reset || ur) ? 3'h0 : up_ff + {2'h0, up_ff != 3'h7};
    sequence hold_s; ur [*5]; endsequence
    sequence release_s; $fell(ur) ##1 !ur [*4]; endsequence
    hold_no_clock_a: assert property (hold_s |-> !datapath_clock_out && !interface_clock_out)
        else $error("clock runs under user reset");
    active_rise_a: assert property (release_s |-> act)
        else $error("active missing after release");
    active_cause_a: assert property ($rose(act) |-> !$past(ur, 2))
        else $error("active rose without release");
    active_drop_a: assert property ($rose(ur) ##1 ur [*4] |-> !act)
        else $error("active kept under user reset");
    source_export_a: assert property (up_ff > 3'h3 |->
        source_clock_out == $past(rx_recovered_clock_out, 2)) else $error("source export wrong");
    clock_export_a: assert property (datapath_clock_out == rx_datapath_clock_in
        && interface_clock_out == rx_interface_clock_in) else $error("clock export wrong");
    iface_follow_a: assert property (up_ff > 3'h4 && $changed(interface_clock_out) |->
        $changed(datapath_clock_out)) else $error("interface clock off datapath");
    channel_copy_a: assert property (user_clk_active == {NUM_CHANNELS{act}})
        else $error("channels differ");
endmodule // rucn_top_sva
bind rucn_top rucn_top_sva #(.NUM_CHANNELS(NUM_CHANNELS), .MASTER_CHAN(MASTER_CHAN)) chk (
    .core_clk(core_clk), .reset(reset), .rx_recovered_clock_out(rx_recovered_clock_out),
    .rx_datapath_clock_in(rx_datapath_clock_in), .rx_interface_clock_in(rx_interface_clock_in),
    .user_clk_reset(user_clk_reset), .source_clock_out(source_clock_out),
    .datapath_clock_out(datapath_clock_out), .interface_clock_out(interface_clock_out),
    .user_clk_active(user_clk_active));
`default_nettype wire

/* File: dv/rucn_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module rucn_top_tb;
    logic       core_clk = 1'b0;
    logic       reset    = 1'b1;
    logic [3:0] ur       = 4'hF;
    logic       start    = 1'b0;
    logic [7:0] num      = 8'h00;
    logic [3:0] rec, dpi, ifi, src, dpo, ifo, dpr, ifr, act;
    logic [3:0] ndpi, nifi, nsrc, ndpo, nifo, ndpr, nifr, nact;
    logic [15:0] dp_n = 16'h0000, if_n = 16'h0000, b0, b1;
    logic [15:0] nif_n = 16'h0000, b2;
    int         fails = 0, compares = 0, cyc = 0;
    always #4 core_clk = ~core_clk;
    rucn_top #(.WIDE_USER(1'b1)) dut (.core_clk(core_clk), .reset(reset),
        .rx_recovered_clock_out(rec), .rx_datapath_clock_in(dpi), .rx_interface_clock_in(ifi),
        .user_clk_reset(ur), .source_clock_out(src), .datapath_clock_out(dpo),
        .interface_clock_out(ifo), .datapath_rise(dpr), .interface_rise(ifr), .user_clk_active(act));
    // narrow, per-channel instance: one buffer drives both clocks of each channel
    rucn_top #(.WIDE_USER(1'b0), .SINGLE_LANE_BYPASS(1'b1)) dut_narrow (.core_clk(core_clk),
        .reset(reset), .rx_recovered_clock_out(rec), .rx_datapath_clock_in(ndpi),
        .rx_interface_clock_in(nifi), .user_clk_reset(ur), .source_clock_out(nsrc),
        .datapath_clock_out(ndpo), .interface_clock_out(nifo), .datapath_rise(ndpr),
        .interface_rise(nifr), .user_clk_active(nact));
    rucn_chan_model #(.N(4)) chan (.core_clk(core_clk), .start(start), .num(num), .rec_clk(rec));
    // count rise pulses of channel 0, and of channel 3 of the narrow instance; cut a hang short
    always @(negedge core_clk) begin
        dp_n <= dp_n + {15'h0000, dpr[0]};
        if_n <= if_n + {15'h0000, ifr[0]};
        nif_n <= nif_n + {15'h0000, nifr[3]};
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            complete_run;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic burst(input logic [7:0] n, input int wait_cyc);
        start = 1'b1;
        num   = n;
        @(negedge core_clk);
        start = 1'b0;
        repeat (wait_cyc) @(negedge core_clk);
    endtask
    task automatic test_hold;
        b0 = dp_n;
        burst(8'h08, 36);
        check(dp_n - b0, 16'h0000);
        check(16'(act), 16'h0000);
        $display("test hold done");
    endtask
    task automatic test_run;
        ur = 4'h0;
        repeat (6) @(negedge core_clk);
        check(16'(act), 16'h000F);
        b0 = dp_n;
        b1 = if_n;
        b2 = nif_n;
        burst(8'h18, 84);
        check(dp_n - b0, 16'h000C);
        check(if_n - b1, 16'h0006);
        check(nif_n - b2, 16'h000C);
        check({12'h000, nact}, 16'h000F);
        check({8'h00, ifo, dpo}, {8'h00, ifi, dpi});
        $display("test run done");
    endtask
    task automatic test_reassert;
        burst(8'h28, 20);
        ur = 4'hF;
        repeat (5) @(negedge core_clk);
        check(16'(act), 16'h0000);
        b0 = dp_n;
        repeat (40) @(negedge core_clk);
        check(dp_n - b0, 16'h0000);
        ur = 4'h0;
        repeat (6) @(negedge core_clk);
        check(16'(act), 16'h000F);
        $display("test reassert done");
    endtask
    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // user reset stays high until the source is settled
    initial begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        test_hold;
        test_run;
        test_reassert;
        complete_run;
    end
endmodule // rucn_top_tb
`default_nettype wire

/* File: logic/rucn_div_buf.sv */
`timescale 1ns/100ps
`default_nettype none
module rucn_div_buf #(
    parameter int DIV = rucn_pkg::DIV_DATAPATH_DEF
) (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   reset,
    // control side
    rucn_div_if.buf_side dif
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;
    logic          clk_ff;
    logic          rise_ff;

    // ----------------------------------------------------------------
    // divider decode
    // ----------------------------------------------------------------
    wire hold     = reset | dif.buf_reset;
    wire wrap     = dif.src_edge & (cnt_ff == LAST);
    wire [CW-1:0] nxt_cnt = wrap ? '0 : (dif.src_edge ? cnt_ff + CW'(1) : cnt_ff);

    // count source edges, toggle output each DIV edges
    always_ff @(posedge core_clk) begin
        if (hold) begin
            cnt_ff  <= '0;
            clk_ff  <= rucn_pkg::RST_DIV_CLK;
            rise_ff <= 1'h0;
        end else begin
            cnt_ff  <= nxt_cnt;
            clk_ff  <= wrap ? ~clk_ff : clk_ff;
            rise_ff <= wrap & ~clk_ff;
        end
    end

    assign dif.div_clk  = clk_ff;
    assign dif.div_rise = rise_ff;
endmodule : rucn_div_buf
`default_nettype wire

/* File: logic/rucn_div_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface rucn_div_if;
    logic buf_reset;
    logic src_edge;
    logic div_clk;
    logic div_rise;
    modport buf_side (input buf_reset, input src_edge, output div_clk, output div_rise);
    modport ctl_side (output buf_reset, output src_edge, input div_clk, input div_rise);
endinterface : rucn_div_if
`default_nettype wire

/* File: logic/rucn_pkg.sv */
`default_nettype none
package rucn_pkg;
    // ----------------------------------------------------------------
    // structure defaults
    // ----------------------------------------------------------------
    localparam int NUM_CHANNELS_DEF  = 4;
    localparam int MASTER_CHAN_DEF   = 0;
    // division ratio of the datapath buffer, in source clock periods
    localparam int DIV_DATAPATH_DEF  = 1;
    // interface clock runs at half the datapath rate in wide mode
    localparam int WIDE_RATIO        = 2;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RST_ACTIVE      = 1'h0;
    localparam logic RST_DIV_CLK     = 1'h0;
    localparam logic RST_SYNC_RESET  = 1'h1;
    localparam logic RST_SRC_LEVEL   = 1'h0;
endpackage : rucn_pkg
`default_nettype wire

/* File: logic/rucn_top.sv */
// Behaviour
// - one clocking instance serves the core, or one per channel in single-lane bypass mode.
// - the source is the master channel recovered clock, or the own channel's in bypass mode.
// - with narrow user width one dividing buffer drives both datapath and interface clocks.
// - with wide user width two buffers make a datapath clock at twice the interface rate.
// - each buffer divides the source down to the rate its output needs.
// - while the user clock reset is high every buffer is held and gives no clock.
// - after the user clock reset is released the active indicator asserts synchronously.
// - the chosen source clock is also exported as a source clock output.
// - the datapath and interface clocks are also exported for user logic.
`timescale 1ns/100ps
`default_nettype none
module rucn_top #(
    parameter int NUM_CHANNELS       = rucn_pkg::NUM_CHANNELS_DEF,
    parameter int MASTER_CHAN        = rucn_pkg::MASTER_CHAN_DEF,
    parameter bit SINGLE_LANE_BYPASS = 1'b0,
    parameter bit WIDE_USER          = 1'b0,
    parameter int DIV_DATAPATH       = rucn_pkg::DIV_DATAPATH_DEF
) (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // transceiver channel side
    input  wire logic [NUM_CHANNELS-1:0] rx_recovered_clock_out,
    output logic      [NUM_CHANNELS-1:0] rx_datapath_clock_in,
    output logic      [NUM_CHANNELS-1:0] rx_interface_clock_in,
    // user side
    input  wire logic [NUM_CHANNELS-1:0] user_clk_reset,
    output logic      [NUM_CHANNELS-1:0] source_clock_out,
    output logic      [NUM_CHANNELS-1:0] datapath_clock_out,
    output logic      [NUM_CHANNELS-1:0] interface_clock_out,
    output logic      [NUM_CHANNELS-1:0] datapath_rise,
    output logic      [NUM_CHANNELS-1:0] interface_rise,
    output logic      [NUM_CHANNELS-1:0] user_clk_active
);
    // ----------------------------------------------------------------
    // instance count
    // ----------------------------------------------------------------
    localparam int NUM_INST = SINGLE_LANE_BYPASS ? NUM_CHANNELS : 1;
    localparam int DIV_IFC  = WIDE_USER ? DIV_DATAPATH * rucn_pkg::WIDE_RATIO : DIV_DATAPATH;

    // per-instance clock results
    logic [NUM_INST-1:0] inst_src;
    logic [NUM_INST-1:0] inst_dp_clk;
    logic [NUM_INST-1:0] inst_if_clk;
    logic [NUM_INST-1:0] inst_dp_rise;
    logic [NUM_INST-1:0] inst_if_rise;
    logic [NUM_INST-1:0] inst_active;

    // ----------------------------------------------------------------
    // clocking instances
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_INST; i++) begin : g_inst
        logic src_meta_ff;
        logic src_sync_ff;
        logic src_prev_ff;
        logic rst_meta_ff;
        logic rst_sync_ff;
        logic active_ff;

        // source and reset selection
        wire src_pin = SINGLE_LANE_BYPASS ? rx_recovered_clock_out[i]
                                          : rx_recovered_clock_out[MASTER_CHAN];
        wire rst_pin = SINGLE_LANE_BYPASS ? user_clk_reset[i]
                                          : user_clk_reset[MASTER_CHAN];
        wire src_edge = src_sync_ff ^ src_prev_ff;

        // two-stage capture of the recovered clock
        always_ff @(posedge core_clk) begin
            if (reset) begin
                src_meta_ff <= rucn_pkg::RST_SRC_LEVEL;
                src_sync_ff <= rucn_pkg::RST_SRC_LEVEL;
                src_prev_ff <= rucn_pkg::RST_SRC_LEVEL;
            end else begin
                src_meta_ff <= src_pin;
                src_sync_ff <= src_meta_ff;
                src_prev_ff <= src_sync_ff;
            end
        end

        // two-stage capture of the user clock reset
        always_ff @(posedge core_clk) begin
            if (reset) begin
                rst_meta_ff <= rucn_pkg::RST_SYNC_RESET;
                rst_sync_ff <= rucn_pkg::RST_SYNC_RESET;
            end else begin
                rst_meta_ff <= rst_pin;
                rst_sync_ff <= rst_meta_ff;
            end
        end

        // active indicator follows the released reset
        always_ff @(posedge core_clk) begin
            if (reset || rst_sync_ff) begin
                active_ff <= rucn_pkg::RST_ACTIVE;
            end else begin
                active_ff <= 1'h1;
            end
        end

        rucn_div_if dp_if ();
        assign dp_if.buf_reset = rst_sync_ff;
        assign dp_if.src_edge  = src_edge;

        // datapath dividing buffer
        rucn_div_buf #(
            .DIV (DIV_DATAPATH)
        ) u_dp_buf (
            .core_clk (core_clk),
            .reset    (reset),
            .dif      (dp_if.buf_side)
        );

        if (WIDE_USER) begin : g_wide
            rucn_div_if if_if ();
            assign if_if.buf_reset = rst_sync_ff;
            assign if_if.src_edge  = src_edge;

            // interface dividing buffer at half the datapath rate
            rucn_div_buf #(
                .DIV (DIV_IFC)
            ) u_if_buf (
                .core_clk (core_clk),
                .reset    (reset),
                .dif      (if_if.buf_side)
            );
            assign inst_if_clk[i]  = if_if.div_clk;
            assign inst_if_rise[i] = if_if.div_rise;
        end else begin : g_narrow
            assign inst_if_clk[i]  = dp_if.div_clk;
            assign inst_if_rise[i] = dp_if.div_rise;
        end

        assign inst_src[i]     = src_sync_ff;
        assign inst_dp_clk[i]  = dp_if.div_clk;
        assign inst_dp_rise[i] = dp_if.div_rise;
        assign inst_active[i]  = active_ff;
    end

    // ----------------------------------------------------------------
    // channel and boundary wiring
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
        localparam int SEL = SINGLE_LANE_BYPASS ? c : 0;
        // internal channel clocks
        assign rx_datapath_clock_in[c]  = inst_dp_clk[SEL];
        assign rx_interface_clock_in[c] = inst_if_clk[SEL];
        // exported copies for user logic
        assign source_clock_out[c]      = inst_src[SEL];
        assign datapath_clock_out[c]    = inst_dp_clk[SEL];
        assign interface_clock_out[c]   = inst_if_clk[SEL];
        assign datapath_rise[c]         = inst_dp_rise[SEL];
        assign interface_rise[c]        = inst_if_rise[SEL];
        assign user_clk_active[c]       = inst_active[SEL];
    end
endmodule : rucn_top
`default_nettype wire

/* File: logic/unused_placeholder_none.sv */
`default_nettype none
`default_nettype wire
